/* common/fir_seq_pkg.sv */
// package: constants and types for the fir coefficient sequencer
package fir_seq_pkg;
  localparam int unsigned SEL_W = 5;
  localparam int unsigned ADDR_W = 9;
  localparam int unsigned COEF_W = 12;
  localparam int unsigned OUT_W = 16;
  localparam int unsigned CTRL_W = 20;
  localparam int unsigned WORD_W = 36;
  localparam int unsigned STORE_DEPTH = 448;
  localparam int unsigned TAPS_8 = 8;
  localparam int unsigned TAPS_12 = 12;
  localparam logic [7:0] MASK_8TAP = 8'hf8;
  localparam logic [7:0] MASK_12TAP = 8'hf4;
  localparam logic [COEF_W-1:0] COEF_RESET = 12'h000;
  localparam logic MEM_EN_N_RESET = 1'b1;
  localparam int unsigned JUMP_CYCLES = 2;
  localparam int unsigned SELECT_LATENCY = 3;
  localparam int unsigned CLK_PERIOD_PS = 5000;
  // register port map
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_WADDR = 4'h8;
  localparam logic [3:0] REG_WDATA = 4'hc;
  localparam int unsigned CTRL_TAP12_BIT = 0;
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_DONE_BIT = 1;
  typedef enum logic [1:0] {
    ST_WAIT,
    ST_JUMP,
    ST_STREAM
  } seq_state_t;
endpackage : fir_seq_pkg

/* common/ustore_if.sv */
// interface: microcode store access between sequencer and store
`timescale 1ns/100ps
`default_nettype none
interface ustore_if;
  import fir_seq_pkg::*;
  logic [ADDR_W-1:0] rd_addr;
  logic [WORD_W-1:0] rd_word;
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [WORD_W-1:0] wr_word;
  modport seq (output rd_addr, input rd_word,
               output wr_en, output wr_addr, output wr_word);
  modport store (input rd_addr, output rd_word,
                 input wr_en, input wr_addr, input wr_word);
endinterface : ustore_if
`default_nettype wire

/* logic/ustore_mem.sv */
// module: microcode store, one 36-bit word per address
`timescale 1ns/100ps
`default_nettype none
module ustore_mem #(
  parameter int unsigned DEPTH = fir_seq_pkg::STORE_DEPTH
) (
  // clock
  input wire logic i_mclk,
  // store port
  ustore_if.store bus
);
  import fir_seq_pkg::*;
  if (DEPTH > (1 << ADDR_W)) begin : g_bad_depth
    $error("depth exceeds address space");
  end
  logic [WORD_W-1:0] mem [DEPTH];
  logic [WORD_W-1:0] rd_q;
  always_ff @(posedge i_mclk) begin
    if (bus.wr_en && (32'(bus.wr_addr) < DEPTH)) begin
      mem[bus.wr_addr] <= bus.wr_word;
    end
    rd_q <= (32'(bus.rd_addr) < DEPTH) ? mem[bus.rd_addr] : '0;
  end
  assign bus.rd_word = rd_q;
endmodule : ustore_mem
`default_nettype wire

/* logic/fir_coefficient_sequencer.sv */
// module: selectable fir coefficient sequencer, top level
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module fir_coefficient_sequencer #(
  parameter int unsigned DEPTH = fir_seq_pkg::STORE_DEPTH,
  parameter int unsigned STACK_DEPTH = 4
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_resetn,
  // table request pins
  input wire logic i_load_coeff_req,
  input wire logic [fir_seq_pkg::SEL_W-1:0] i_table_sel,
  // coefficient outputs
  output logic [fir_seq_pkg::COEF_W-1:0] o_coef_out,
  output logic o_data_mem_enable_n,
  output logic o_stop_data,
  // register port
  input wire logic [3:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata
);
  import fir_seq_pkg::*;

  // ****************************************
  // parameter checks
  // ****************************************
  // the store address is ADDR_W bits wide; deeper stores cannot be reached
  if (DEPTH > (1 << ADDR_W)) begin : g_bad_depth
    $error("store depth exceeds the address range");
  end
  // a push lands in slot 0, so the stack needs at least one slot
  if (STACK_DEPTH < 1 || STACK_DEPTH > 16) begin : g_bad_stack
    $error("stack depth out of range");
  end
  // a store smaller than one table cannot hold any coefficient set
  if (DEPTH < TAPS_8) begin : g_bad_small
    $error("store too small for one table");
  end

  // ****************************************
  // pin synchronisers
  // ****************************************
  // three stages; a change counts once stages two and three agree, so a
  // pin caught in mid-change is never taken as a request
  logic [2:0] ld_sync_q;
  logic [SEL_W-1:0] sel_s1_q;
  logic [SEL_W-1:0] sel_s2_q;
  logic [SEL_W-1:0] sel_s3_q;
  logic ld_clean_q;
  logic [SEL_W-1:0] sel_clean_q;
  wire ld_agree = (ld_sync_q[1] == ld_sync_q[2]);
  wire sel_agree = (sel_s2_q == sel_s3_q);

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      ld_sync_q <= 3'h0;
    end else begin
      ld_sync_q <= {ld_sync_q[1:0], i_load_coeff_req};
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      sel_s1_q <= '0;
      sel_s2_q <= '0;
      sel_s3_q <= '0;
    end else begin
      sel_s1_q <= i_table_sel;
      sel_s2_q <= sel_s1_q;
      sel_s3_q <= sel_s2_q;
    end
  end

  // the select settles with the request, as both pass the same stages
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      ld_clean_q <= 1'b0;
      sel_clean_q <= '0;
    end else begin
      if (ld_agree) begin
        ld_clean_q <= ld_sync_q[2];
      end
      if (sel_agree) begin
        sel_clean_q <= sel_s3_q;
      end
    end
  end

  // ****************************************
  // register port
  // ****************************************
  logic tap12_q;
  logic done_q;
  logic [ADDR_W-1:0] waddr_q;
  logic [31:0] rdata_q;
  seq_state_t state_q, state_d;
  // one decode for every register offset keeps the map in one place
  function automatic logic reg_hit(
    input logic [3:0] addr, input logic [3:0] offset);
    reg_hit = (addr == offset);
  endfunction : reg_hit

  wire hit_ctrl = reg_hit(i_reg_addr, REG_CTRL);
  wire hit_status = reg_hit(i_reg_addr, REG_STATUS);
  wire hit_waddr = reg_hit(i_reg_addr, REG_WADDR);
  wire hit_wdata = reg_hit(i_reg_addr, REG_WDATA);
  wire wr_ctrl = i_reg_wr && hit_ctrl;
  wire wr_waddr = i_reg_wr && hit_waddr;
  wire wr_wdata = i_reg_wr && hit_wdata;
  wire busy = (state_q != ST_WAIT);
  wire [31:0] status_word = {30'h0, done_q, busy};
  // unmapped offsets and the write-only data port read as zero
  wire [31:0] rd_mux =
    hit_ctrl ? {31'h0, tap12_q} :
    hit_status ? status_word :
    hit_waddr ? {{(32-ADDR_W){1'b0}}, waddr_q} : 32'h0;

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      tap12_q <= 1'b0;
    end else if (wr_ctrl) begin
      tap12_q <= i_reg_wdata[CTRL_TAP12_BIT];
    end
  end

  // the pointer steps after each data write, so a table loads in order
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      waddr_q <= '0;
    end else if (wr_waddr) begin
      waddr_q <= i_reg_wdata[ADDR_W-1:0];
    end else if (wr_wdata) begin
      waddr_q <= waddr_q + 1'b1;
    end
  end

  // read data stand in each cycle after a cycle with i_reg_rd high and are zero otherwise
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_q <= 32'h0;
    end else begin
      rdata_q <= i_reg_rd ? rd_mux : 32'h0;
    end
  end
  assign o_reg_rdata = rdata_q;

  // ****************************************
  // microcode store
  // ****************************************
  // word layout: [35:16] control, [15:4] coefficient, [0] enable_n;
  // control bit 0 marks the last tap of a table
  ustore_if ubus ();
  ustore_mem #(.DEPTH(DEPTH)) u_store (
    .i_mclk(i_mclk),
    .bus(ubus.store)
  );
  assign ubus.wr_en = wr_wdata;
  assign ubus.wr_addr = waddr_q;
  // a 32-bit write fills the output half and the low control bits
  assign ubus.wr_word = {4'h0, i_reg_wdata};

  // ****************************************
  // sequencer
  // ****************************************
  function automatic logic [7:0] mask_select(
    input logic [SEL_W-1:0] sel, input logic wide);
    logic [7:0] raw;
    raw = {sel, 3'b000};
    mask_select = raw & (wide ? MASK_12TAP : MASK_8TAP);
  endfunction : mask_select

  logic [ADDR_W-1:0] stack_q [STACK_DEPTH];
  logic [ADDR_W-1:0] pc_q, pc_d;
  logic [COEF_W-1:0] coef_q;
  logic mem_en_n_q;
  wire [7:0] push_val = mask_select(sel_clean_q, tap12_q);
  wire last_tap = ubus.rd_word[OUT_W];
  wire [COEF_W-1:0] word_coef = ubus.rd_word[OUT_W-1:4];
  wire word_en_n = ubus.rd_word[0];
  // the store reads with one clock delay; pc_d addresses it, so rd_word holds the word at pc_q
  assign ubus.rd_addr = pc_d;

  always_comb begin
    state_d = state_q;
    pc_d = pc_q;
    unique case (state_q)
      ST_WAIT: begin
        if (ld_clean_q) begin
          state_d = ST_JUMP;
        end
      end
      ST_JUMP: begin
        pc_d = stack_q[0];
        state_d = ST_STREAM;
      end
      ST_STREAM: begin
        if (last_tap) begin
          state_d = ST_WAIT;
        end else begin
          pc_d = pc_q + 1'b1;
        end
      end
    endcase
  end

  wire push_now = (state_q == ST_WAIT) && ld_clean_q;
  wire pop_now = (state_q == ST_JUMP);
  wire streaming = (state_q == ST_STREAM);
  wire finish_now = streaming && last_tap;

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q <= ST_WAIT;
      pc_q <= '0;
    end else begin
      state_q <= state_d;
      pc_q <= pc_d;
    end
  end

  // push and pop never meet: a push only happens in the wait state
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int i = 0; i < STACK_DEPTH; i++) begin
        stack_q[i] <= '0;
      end
    end else if (push_now) begin
      stack_q[0] <= {1'b0, push_val};
      for (int i = 1; i < STACK_DEPTH; i++) begin
        stack_q[i] <= stack_q[i-1];
      end
    end else if (pop_now) begin
      for (int i = 0; i < STACK_DEPTH - 1; i++) begin
        stack_q[i] <= stack_q[i+1];
      end
    end
  end

  // outputs come from flip-flops and show idle values outside the stream
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      coef_q <= COEF_RESET;
      mem_en_n_q <= MEM_EN_N_RESET;
    end else if (streaming) begin
      coef_q <= word_coef;
      mem_en_n_q <= word_en_n;
    end else begin
      coef_q <= COEF_RESET;
      mem_en_n_q <= MEM_EN_N_RESET;
    end
  end

  // set wins over the software clear of the done flag
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      done_q <= 1'b0;
    end else if (finish_now) begin
      done_q <= 1'b1;
    end else if (wr_ctrl) begin
      done_q <= 1'b0;
    end
  end

  // outside logic ANDs this active-low enable with the low clock phase to strobe x data
  assign o_coef_out = coef_q;
  assign o_data_mem_enable_n = mem_en_n_q;
  assign o_stop_data = done_q;
endmodule : fir_coefficient_sequencer
`default_nettype wire

/* verification/fir_seq_props.sv */
// checker: port assertions for the coefficient sequencer
`timescale 1ns/100ps
`default_nettype none
module fir_seq_props (
  // clock, reset, request
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_load_coeff_req,
  // register port
  input wire logic [3:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [31:0] o_reg_rdata,
  // coefficient side
  input wire logic [fir_seq_pkg::COEF_W-1:0] o_coef_out,
  input wire logic o_data_mem_enable_n,
  input wire logic o_stop_data
);
  import fir_seq_pkg::*;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  chk_idle_zero: assert property (
    o_data_mem_enable_n |-> o_coef_out == '0)
    else $error("coefficient not zero while idle");
  chk_reset_idle: assert property (
    $rose(i_resetn) |-> o_data_mem_enable_n && !o_stop_data)
    else $error("outputs not idle after reset");
  chk_stay_idle: assert property (
    (!i_load_coeff_req && o_data_mem_enable_n)[*8] |=> o_data_mem_enable_n)
    else $error("stream started without a request");
  chk_load_stream: assert property (
    $rose(i_load_coeff_req) && o_data_mem_enable_n
      |-> ##[2:8] !o_data_mem_enable_n)
    else $error("stream late after load request");
  chk_stop_last: assert property (
    $rose(o_stop_data)
      |-> !o_data_mem_enable_n ##1 o_data_mem_enable_n)
    else $error("done flag not at end of table");
  chk_stop_clear: assert property (
    $fell(o_stop_data) |-> $past(i_reg_wr) && $past(i_reg_addr) == REG_CTRL)
    else $error("done flag cleared without control write");
  chk_done_read: assert property (
    $past(i_reg_rd) && $past(i_reg_addr) == REG_STATUS
      |-> o_reg_rdata[STAT_DONE_BIT] == $past(o_stop_data))
    else $error("status done bit wrong");
  chk_rdata_quiet: assert property (
    !$past(i_reg_rd) |-> o_reg_rdata == '0)
    else $error("read data outside read slot");
endmodule : fir_seq_props
`default_nettype wire

/* verification/mac_model.sv */
// model: multiplier-accumulator side, counts strobed taps
`timescale 1ns/100ps
`default_nettype none
module mac_model (
  // from the sequencer
  input wire logic i_mclk,
  input wire logic i_mem_enable_n,
  input wire logic [11:0] i_coef,
  // taps taken and last coefficient
  output logic [7:0] o_taps,
  output logic [11:0] o_last
);
  // low clock phase gating keeps the strobe clear of the output edge
  wire x_data_strobe = ~i_mclk & ~i_mem_enable_n;
  initial o_taps = 8'h00;
  always @(posedge x_data_strobe) begin
    o_taps <= o_taps + 8'h01;
    o_last <= i_coef;
  end
endmodule : mac_model
`default_nettype wire

/* verification/testbench.sv */
// testbench: table loads and coefficient streams
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import fir_seq_pkg::*;
  logic mclk, resetn, req, wr, rd, men, stop;
  logic [4:0] sel;
  logic [3:0] addr;
  logic [31:0] wdata, rdata;
  logic [11:0] coef, last;
  logic [7:0] taps;
  int bad_count = 0;
  int total_checks = 0;
  fir_coefficient_sequencer i_dut (.i_mclk(mclk), .i_resetn(resetn),
    .i_load_coeff_req(req), .i_table_sel(sel), .o_coef_out(coef),
    .o_data_mem_enable_n(men), .o_stop_data(stop), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata));
  mac_model i_mac (.i_mclk(mclk), .i_mem_enable_n(men), .i_coef(coef),
    .o_taps(taps), .o_last(last));
  function automatic logic [11:0] cf(input int a);
    return 12'(a * 37 + 5);
  endfunction : cf
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, input logic [31:0] exp);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1 check(rdata, exp);
  endtask : rd_reg
  // one table request, then every tap compared as it streams
  task automatic run(input logic [4:0] s, input int base);
    int n;
    @(posedge mclk);
    sel <= s;
    req <= 1'b1;
    n = 0;
    while (men !== 1'b0 && n < 20) begin
      @(posedge mclk);
      #1 n++;
    end
    if (n == 20) begin
      bad_count++;
      complete_run();
    end
    // four edges through the pin stages, then the select latency
    check(32'(n), 32'(SELECT_LATENCY + 4));
    for (int i = 0; i < 8; i++) begin
      check(32'(coef), 32'(cf(base + i)));
      check(32'(men), 32'h0);
      @(posedge mclk);
      req <= 1'b0;
      #1;
    end
    check({31'h0, men}, 32'h1);
    check({31'h0, stop}, 32'h1);
    check(32'(last), 32'(cf(base + 7)));
    $display("table at %0d done", base);
  endtask : run
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    {resetn, req, wr, rd, sel, addr, wdata} = '0;
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    #1 check({19'h0, coef, men}, 32'h1);
    wr_reg(REG_WADDR, 32'h8);
    for (int a = 8; a < 32; a++)
      wr_reg(REG_WDATA, {15'h0, a[2:0] == 3'h7, cf(a), 4'h0});
    rd_reg(REG_WDATA, 32'h0);
    rd_reg(4'h2, 32'h0);
    run(5'h01, 8);
    check(32'(taps), 32'h8);
    rd_reg(REG_STATUS, 32'h2);
    run(5'h02, 16);
    run(5'h03, 24);
    wr_reg(REG_CTRL, 32'h1);
    rd_reg(REG_STATUS, 32'h0);
    run(5'h03, 16);
    check(32'(taps), 32'h20);
    complete_run();
  end
endmodule : testbench
bind fir_coefficient_sequencer fir_seq_props u_props (.i_mclk, .i_resetn,
  .i_load_coeff_req, .i_reg_addr, .i_reg_wr, .i_reg_rd, .o_reg_rdata,
  .o_coef_out, .o_data_mem_enable_n, .o_stop_data);
`default_nettype wire
